/* include/sxb_cfg.svh */
`ifndef SXB_CFG_SVH
`define SXB_CFG_SVH
`define SXB_OFS_COM2 4'h0
`define SXB_OFS_DDR 4'h1
`define SXB_OFS_ARB 4'h2
`define SXB_OFS_LAST 4'hB
`define SXB_HOST_ARB_OFS 8'h77
`define SXB_TGT_REGS 4'h0
`define SXB_TGT_LCD 4'h1
`define SXB_TGT_CS0 4'h2
`define SXB_TGT_CS3 4'h5
`define SXB_ARB_REQ_BIT 0
`define SXB_ARB_GNT_BIT 1
`define SXB_ARB_MRQ_BIT 2
`define SXB_REG_RESET 8'h00
`define SXB_STROBE_CYCLES 4'h3
`endif

/* include/sxb_pkg.sv */
package sxb_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] wdata;
    } sxb_cmd_s;
    typedef struct packed {
        logic lcd_chip_select;
        logic [3:0] sel;
        logic lcd_latch_strobe;
        logic rd;
        logic wr;
        logic [3:0] expansion_address_pins;
    } sxb_xbus_s;
    typedef enum logic [1:0] {
        SXB_GRANT_HOST,
        SXB_GRANT_SMB
    } sxb_owner_e;
endpackage

/* hw/sxb_arbiter.sv */
`timescale 1ns/1ps
`include "sxb_cfg.svh"
module sxb_arbiter (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic host_side_request,
    input wire logic smbus_side_request,
    input wire logic smbus_side_forcing_request,
    output sxb_pkg::sxb_owner_e owner,
    output logic handover
);
    import sxb_pkg::*;
    sxb_owner_e owner_reg, owner_next;
    logic hreq_q_reg, sreq_q_reg, hreq_q_next, sreq_q_next;
    logic handover_reg, handover_next;

    always_comb begin
        logic h_rise;
        logic s_rise;
        h_rise = host_side_request & ~hreq_q_reg;
        s_rise = smbus_side_request & ~sreq_q_reg;
        owner_next = owner_reg;
        if (smbus_side_forcing_request) begin
            owner_next = SXB_GRANT_SMB;
        end else if (!host_side_request && !smbus_side_request) begin
            owner_next = SXB_GRANT_HOST;
        end else if (owner_reg == SXB_GRANT_HOST) begin
            // host holding with request keeps it, also on a tie (no ping-pong)
            if (smbus_side_request && (!host_side_request || (h_rise && !s_rise))) begin
                owner_next = SXB_GRANT_SMB;
            end
        end else begin
            if (!smbus_side_request) begin
                owner_next = SXB_GRANT_HOST;
            end
        end
        hreq_q_next = host_side_request;
        sreq_q_next = smbus_side_request;
        handover_next = owner_next != owner_reg;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            owner_reg <= SXB_GRANT_HOST;
            // host request boots high; a low history here would fake a rise
            hreq_q_reg <= 1'b1;
            sreq_q_reg <= 1'b0;
            handover_reg <= 1'b0;
        end else begin
            owner_reg <= owner_next;
            hreq_q_reg <= hreq_q_next;
            sreq_q_reg <= sreq_q_next;
            handover_reg <= handover_next;
        end
    end

    assign owner = owner_reg;
    assign handover = handover_reg;

    AST_FORCE_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
        smbus_side_forcing_request |=> owner == SXB_GRANT_SMB)
        else $error("forcing request did not grant smbus side");
    AST_IDLE_HOST: assert property (@(posedge core_clk) disable iff (!resetn)
        (!host_side_request && !smbus_side_request && !smbus_side_forcing_request)
        |=> owner == SXB_GRANT_HOST)
        else $error("idle arbiter did not return grant to host");
    AST_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
        (owner == SXB_GRANT_SMB && smbus_side_request) |=> owner == SXB_GRANT_SMB)
        else $error("smbus holder lost grant while requesting");
    AST_NO_OSC: assert property (@(posedge core_clk) disable iff (!resetn)
        (handover && $stable(host_side_request) && $stable(smbus_side_request)
        && !smbus_side_forcing_request) |=> !handover)
        else $error("grant oscillated with stable requests");
endmodule // sxb_arbiter

/* hw/sxb_bridge.sv */
`timescale 1ns/1ps
`include "sxb_cfg.svh"
module sxb_bridge (
    input wire logic core_clk,
    input wire logic resetn,
    input sxb_pkg::sxb_cmd_s cmd,
    output logic [7:0] rdata,
    output logic rdata_valid,
    input wire logic [7:0] xbus_rdata,
    output sxb_pkg::sxb_xbus_s xbus,
    output logic [7:0] xbus_wdata,
    input wire logic host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_side_bus_arbitration,
    output logic [7:0] com2_disable_reg,
    output logic [7:0] slave_device_disable_reg,
    input wire logic [7:0] elapsed_count [8]
);
    import sxb_pkg::*;

    function automatic logic target_valid(input logic [3:0] hi);
        target_valid = hi <= `SXB_TGT_CS3;
    endfunction

    typedef enum logic [1:0] {SXB_IDLE, SXB_STROBE} sxb_state_e;
    sxb_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    sxb_owner_e owner;
    logic handover;
    logic host_req_reg, host_req_next;
    logic smbus_side_request_reg, smbus_side_request_next, smbus_side_forcing_request_reg, smbus_side_forcing_request_next;
    logic [7:0] com2_reg, com2_next, ddr_reg, ddr_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    sxb_xbus_s xbus_reg, xbus_next;
    logic [7:0] xwd_reg, xwd_next;
    logic [7:0] harb_reg, harb_next;

    sxb_arbiter u_arb (
        .core_clk(core_clk),
        .resetn(resetn),
        .host_side_request(host_req_reg),
        .smbus_side_request(smbus_side_request_reg),
        .smbus_side_forcing_request(smbus_side_forcing_request_reg),
        .owner(owner),
        .handover(handover)
    );

    always_comb begin
        logic [3:0] hi;
        logic [3:0] lo;
        logic smbus_side_grant;
        hi = cmd.code[7:4];
        lo = cmd.code[3:0];
        smbus_side_grant = owner == SXB_GRANT_SMB;
        state_next = state_reg;
        cnt_next = cnt_reg;
        host_req_next = host_req_reg;
        smbus_side_request_next = smbus_side_request_reg;
        smbus_side_forcing_request_next = smbus_side_forcing_request_reg;
        com2_next = com2_reg;
        ddr_next = ddr_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        xbus_next = xbus_reg;
        xwd_next = xwd_reg;
        if (host_wr && host_addr == `SXB_HOST_ARB_OFS) begin
            host_req_next = host_wdata[`SXB_ARB_REQ_BIT];
        end
        unique case (state_reg)
            SXB_IDLE: begin
                if (cmd.valid && hi == `SXB_TGT_REGS) begin
                    // undefined offsets fall through untouched
                    if (lo <= `SXB_OFS_LAST) begin
                        rvalid_next = ~cmd.write;
                        unique case (lo)
                            `SXB_OFS_COM2: rdata_next = com2_reg;
                            `SXB_OFS_DDR: rdata_next = ddr_reg;
                            `SXB_OFS_ARB: rdata_next = {5'h00, smbus_side_forcing_request_reg, smbus_side_grant, smbus_side_request_reg};
                            4'h3: rdata_next = 8'h00;
                            default: rdata_next = elapsed_count[3'(lo - 4'h4)];
                        endcase
                        if (cmd.write && lo == `SXB_OFS_COM2) com2_next = cmd.wdata;
                        if (cmd.write && lo == `SXB_OFS_DDR) ddr_next = cmd.wdata;
                        if (cmd.write && lo == `SXB_OFS_ARB) begin
                            smbus_side_request_next = cmd.wdata[`SXB_ARB_REQ_BIT];
                            smbus_side_forcing_request_next = cmd.wdata[`SXB_ARB_MRQ_BIT];
                        end
                    end
                end else if (cmd.valid && target_valid(hi) && smbus_side_grant) begin
                    // ungranted expansion commands are dropped, host polls grant first
                    xbus_next.expansion_address_pins = lo;
                    xbus_next.lcd_chip_select = hi == `SXB_TGT_LCD;
                    xbus_next.sel = '0;
                    if (hi == `SXB_TGT_LCD) begin
                        xbus_next.sel[1] = 1'b1;
                    end else begin
                        xbus_next.sel[2'(hi - `SXB_TGT_CS0)] = 1'b1;
                    end
                    xbus_next.rd = (hi == `SXB_TGT_LCD) ? lo[0] : ~cmd.write;
                    xbus_next.wr = (hi == `SXB_TGT_LCD) ? ~lo[0] : cmd.write;
                    xbus_next.lcd_latch_strobe = hi == `SXB_TGT_LCD;
                    xwd_next = cmd.wdata;
                    cnt_next = `SXB_STROBE_CYCLES;
                    state_next = SXB_STROBE;
                end
            end
            SXB_STROBE: begin
                cnt_next = cnt_reg - 4'h1;
                if (handover || cnt_reg == 4'h1) begin
                    if (xbus_reg.rd && !handover) begin
                        rdata_next = xbus_rdata;
                        rvalid_next = 1'b1;
                    end
                    xbus_next = '0;
                    state_next = SXB_IDLE;
                end
            end
            default: state_next = SXB_IDLE;
        endcase
        harb_next = {6'h00, owner == SXB_GRANT_HOST, host_req_next};
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SXB_IDLE;
            cnt_reg <= 4'h0;
            host_req_reg <= 1'b1;
            smbus_side_request_reg <= 1'b0;
            smbus_side_forcing_request_reg <= 1'b0;
            com2_reg <= `SXB_REG_RESET;
            ddr_reg <= `SXB_REG_RESET;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            xbus_reg <= '0;
            xwd_reg <= 8'h00;
            harb_reg <= 8'h03;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            host_req_reg <= host_req_next;
            smbus_side_request_reg <= smbus_side_request_next;
            smbus_side_forcing_request_reg <= smbus_side_forcing_request_next;
            com2_reg <= com2_next;
            ddr_reg <= ddr_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            xbus_reg <= xbus_next;
            xwd_reg <= xwd_next;
            harb_reg <= harb_next;
        end
    end

    assign rdata = rdata_reg;
    assign rdata_valid = rvalid_reg;
    assign xbus = xbus_reg;
    assign xbus_wdata = xwd_reg;
    assign host_side_bus_arbitration = harb_reg;
    assign com2_disable_reg = com2_reg;
    assign slave_device_disable_reg = ddr_reg;

    AST_NO_SEL_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_reg == SXB_IDLE && cmd.valid && cmd.code[7:4] > 4'h5) |=> xbus.sel == 4'h0)
        else $error("select asserted for unused target");
    AST_LCD_SEL: assert property (@(posedge core_clk) disable iff (!resetn)
        xbus.lcd_chip_select |-> (xbus.sel == 4'h2 && xbus.lcd_latch_strobe))
        else $error("lcd select without select one and strobe");
    AST_ONEHOT: assert property (@(posedge core_clk) disable iff (!resetn)
        $onehot0(xbus.sel))
        else $error("more than one expansion select");
    AST_DIR: assert property (@(posedge core_clk) disable iff (!resetn)
        xbus.lcd_chip_select |-> xbus.rd == xbus.expansion_address_pins[0])
        else $error("lcd direction not from command bit zero");
    AST_UNDEF: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_reg == SXB_IDLE && cmd.valid && cmd.code[7:4] == 4'h0 && cmd.code[3:0] > 4'hB)
        |=> ($stable(com2_reg) && $stable(ddr_reg) && !rdata_valid))
        else $error("undefined register command had effect");
    AST_GRANT_RO: assert property (@(posedge core_clk) disable iff (!resetn)
        (!smbus_side_forcing_request_reg && !smbus_side_request_reg && !host_req_reg) |=> ##1 owner == SXB_GRANT_HOST)
        else $error("grant not driven by hardware");
    AST_ONLY_GRANTED: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(state_reg == SXB_STROBE) |-> $past(owner) == SXB_GRANT_SMB)
        else $error("expansion cycle without grant");
    AST_RESET_HOST: assert property (@(posedge core_clk)
        $rose(resetn) |-> owner == SXB_GRANT_HOST)
        else $error("host side not granted after reset");
    AST_ABORT: assert property (@(posedge core_clk) disable iff (!resetn)
        (state_reg == SXB_STROBE && handover) |=> (xbus.sel == 4'h0 && !rdata_valid))
        else $error("expansion cycle not ended on handover");
endmodule // sxb_bridge

/* verif/sxb_xdev_model.sv */
`timescale 1ns/1ps
module sxb_xdev_model (
    input wire logic core_clk,
    input sxb_pkg::sxb_xbus_s xbus,
    input wire logic [7:0] xbus_wdata,
    output logic [7:0] xbus_rdata,
    output logic [7:0] dev_wdata
);
    import sxb_pkg::*;
    logic [7:0] idle_reg = 8'h5A;
    logic picked;
    assign picked = xbus.lcd_chip_select | (|xbus.sel);
    // unselected bus toggles so a stale sample never matches
    assign xbus_rdata = (picked && xbus.rd) ? {xbus.sel, xbus.expansion_address_pins} : idle_reg;
    always_ff @(posedge core_clk) begin
        idle_reg <= ~idle_reg;
        if (picked && xbus.wr) begin
            dev_wdata <= xbus_wdata;
        end
    end
endmodule // sxb_xdev_model

/* verif/sxb_bridge_tb.sv */
`timescale 1ns/1ps
module sxb_bridge_tb;
    import sxb_pkg::*;
    logic core_clk;
    logic resetn;
    sxb_cmd_s cmd;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [7:0] xbus_rdata;
    sxb_xbus_s xbus;
    logic [7:0] xbus_wdata;
    logic host_wr;
    logic [7:0] host_addr;
    logic [7:0] host_wdata;
    logic [7:0] host_arb;
    logic [7:0] com2_q;
    logic [7:0] ddr_q;
    logic [7:0] elapsed [8];
    logic [7:0] dev_wdata;
    int failures;
    int checks;
    logic got;
    logic act;
    logic [7:0] rd_q;
    sxb_xbus_s snap;
    sxb_bridge u_dut (.core_clk(core_clk), .resetn(resetn), .cmd(cmd), .rdata(rdata),
        .rdata_valid(rdata_valid), .xbus_rdata(xbus_rdata), .xbus(xbus),
        .xbus_wdata(xbus_wdata), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_side_bus_arbitration(host_arb),
        .com2_disable_reg(com2_q), .slave_device_disable_reg(ddr_q), .elapsed_count(elapsed));
    sxb_xdev_model u_xdev (.core_clk(core_clk), .xbus(xbus), .xbus_wdata(xbus_wdata),
        .xbus_rdata(xbus_rdata), .dev_wdata(dev_wdata));
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // one command byte plus data byte; watches the bus for 8 cycles or until answered
    task automatic send(input logic w, input logic [7:0] c, input logic [7:0] d, input logic e);
        got = 1'h0;
        act = 1'h0;
        @(posedge core_clk);
        cmd <= '{1'h1, w, c, d};
        @(posedge core_clk);
        cmd.valid <= 1'h0;
        // first look right after the taking edge: rdata_valid stands one cycle only
        for (int i = 0; i < 8 && !got; i++) begin
            if (i > 0) @(posedge core_clk);
            #1;
            if (i == 0) snap = xbus;
            act |= (xbus != '0);
            got = (rdata_valid === 1'h1);
            rd_q = rdata;
        end
        if (e && !got) begin
            cmp(8'h00, 8'h01, "no answer");
            close_out();
        end
    endtask
    task automatic hwr(input logic [7:0] d);
        @(posedge core_clk);
        host_wr <= 1'h1;
        host_addr <= 8'h77;
        host_wdata <= d;
        @(posedge core_clk);
        host_wr <= 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic arb(input logic [7:0] h, input logic [7:0] s, input string m);
        cmp(host_arb, h, m);
        send(1'h0, 8'h02, 8'h00, 1'h1);
        cmp(rd_q, s, m);
    endtask
    task automatic t_regs();
        arb(8'h03, 8'h00, "arb after reset");
        send(1'h1, 8'h00, 8'hA5, 1'h0);
        send(1'h1, 8'h01, 8'h3C, 1'h0);
        send(1'h1, 8'h03, 8'hFF, 1'h0);
        cmp(com2_q, 8'hA5, "reg 00");
        cmp(ddr_q, 8'h3C, "reg 01");
        for (int k = 0; k < 12; k++) begin
            send(1'h0, 8'(k), 8'h00, 1'h1);
            cmp(rd_q, k == 0 ? 8'hA5 : k == 1 ? 8'h3C : k < 4 ? 8'h00 : elapsed[(k + 4) % 8],
                "reg read");
            cmp({7'h00, act}, 8'h00, "reg access drove bus");
        end
        send(1'h0, 8'h0C, 8'h00, 1'h0);
        cmp({7'h00, got}, 8'h00, "undefined offset answered");
        // low nibble 1 keeps lcd direction consistent with a read
        for (int h = 1; h < 16; h++) begin
            send(1'h0, {4'(h), 4'h1}, 8'h00, 1'h0);
            cmp({6'h00, got, act}, 8'h00, "refused command acted");
        end
        cmp(com2_q, 8'hA5, "reg changed by refused command");
    endtask
    task automatic t_arb();
        send(1'h1, 8'h02, 8'h02, 1'h0);
        arb(8'h03, 8'h00, "grant bit written");
        hwr(8'h00);
        arb(8'h02, 8'h00, "idle grant");
        hwr(8'h01);
        send(1'h1, 8'h02, 8'h01, 1'h0);
        arb(8'h03, 8'h01, "holder lost grant");
        hwr(8'h00);
        arb(8'h00, 8'h03, "early release");
        hwr(8'h01);
        arb(8'h01, 8'h03, "smbus grant taken");
    endtask
    task automatic t_xfer();
        logic [3:0] t;
        logic [3:0] es;
        logic w;
        for (int j = 0; j < 12; j++) begin
            t = j < 4 ? 4'h1 : 4'(2 + (j - 4) / 2);
            es = t == 4'h1 ? 4'h2 : 4'h1 << (t - 4'h2);
            w = ~j[0];
            send(w, {t, 4'(j)}, 8'hC0 + 8'(j), ~w);
            cmp({4'h0, snap.sel}, {4'h0, es}, "select");
            cmp({3'h0, snap.lcd_chip_select, snap.expansion_address_pins},
                {3'h0, t == 4'h1, 4'(j)}, "lcd select or address");
            cmp({6'h00, snap.rd, snap.wr}, {6'h00, ~w, w}, "direction");
            if (t == 4'h1) cmp({7'h00, snap.lcd_latch_strobe}, 8'h01, "latch");
            cmp(w ? dev_wdata : rd_q, w ? 8'hC0 + 8'(j) : {es, 4'(j)}, "data");
        end
    endtask
    task automatic t_force();
        logic h;
        send(1'h1, 8'h02, 8'h00, 1'h0);
        arb(8'h03, 8'h00, "holder released");
        send(1'h1, 8'h02, 8'h04, 1'h0);
        arb(8'h01, 8'h06, "forced grant");
        send(1'h1, 8'h02, 8'h00, 1'h0);
        hwr(8'h00);
        arb(8'h02, 8'h00, "grant home");
        fork
            hwr(8'h01);
            send(1'h1, 8'h02, 8'h01, 1'h0);
        join
        h = host_arb[1];
        send(1'h0, 8'h02, 8'h00, 1'h1);
        cmp({7'h00, h ^ rd_q[1]}, 8'h01, "one winner");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            #1;
            cmp({7'h00, host_arb[1]}, {7'h00, h}, "grant moved");
        end
    endtask
    task automatic t_abort();
        int n;
        send(1'h1, 8'h02, 8'h04, 1'h0);
        @(posedge core_clk);
        cmd <= '{1'h1, 1'h1, 8'h02, 8'h00};
        @(posedge core_clk);
        // read accepted on the stale grant, then cut by the handover
        cmd <= '{1'h1, 1'h0, 8'h23, 8'h00};
        @(posedge core_clk);
        cmd.valid <= 1'h0;
        n = 0;
        got = 1'h0;
        for (int i = 0; i < 8; i++) begin
            if (i > 0) @(posedge core_clk);
            #1;
            n += int'(xbus.sel != 4'h0);
            got |= (rdata_valid === 1'h1);
        end
        cmp(8'(n), 8'h01, "aborted cycle length");
        cmp({7'h00, got}, 8'h00, "aborted read answered");
        cmp(host_arb, 8'h03, "waiting side granted");
    endtask
    initial begin
        resetn = 1'h0;
        cmd = '0;
        host_wr = 1'h0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
        failures = 0;
        checks = 0;
        for (int k = 0; k < 8; k++) elapsed[k] = 8'h40 + 8'(k);
        repeat (3) @(posedge core_clk);
        resetn <= 1'h1;
        t_regs();
        t_arb();
        t_xfer();
        t_force();
        t_abort();
        close_out();
    end
endmodule // sxb_bridge_tb
